// ### rtl/tmc_pkg.sv
/*
 * shared constants, types and decode functions of the channel mode control block.
 * assumes a single 125 MHz kernel clock; all slower sampling rates are enables.
 */
package tmc_pkg;

   // -------------------------------------------------------------
   // register map (byte addresses, one word each)
   // -------------------------------------------------------------
   localparam logic [7:0]  ADDR_MODE  = 8'h00;  // channel_mode_control_low
   localparam logic [7:0]  ADDR_CTRL  = 8'h04;  // enables, protection, sampling divider
   localparam logic [7:0]  ADDR_CMPV  = 8'h08;  // chan0_compare_value
   localparam logic [7:0]  ADDR_STAT  = 8'h0C;  // live state, read only
   localparam logic [15:0] MODE_RESET = 16'h0000;
   localparam logic [7:0]  CTRL_RESET = 8'h00;
   localparam logic [15:0] CMPV_RESET = 16'h0000;

   // -------------------------------------------------------------
   // field positions
   // -------------------------------------------------------------
   localparam int MODE_DIR0_LSB    = 0;
   localparam int MODE_QUICK_BIT   = 2;
   localparam int MODE_PRELOAD_BIT = 3;
   localparam int MODE_CMP_LSB     = 4;
   localparam int MODE_DIR1_LSB    = 8;
   localparam int CTRL_ON_LSB      = 0;
   localparam int CTRL_PROTECTION_LEVEL_LSB    = 2;
   localparam int CTRL_SPM_BIT     = 4;
   localparam int CTRL_TRGVLD_BIT  = 5;
   localparam int CTRL_DTS_LSB     = 6;

   // -------------------------------------------------------------
   // codes and timing
   // -------------------------------------------------------------
   localparam logic [2:0] CMP_TIMING = 3'h0;
   localparam logic [2:0] CMP_PWM0   = 3'h6;
   localparam logic [2:0] CMP_PWM1   = 3'h7;
   localparam logic [1:0] DIR_OUT    = 2'h0;
   localparam logic [1:0] DIR_OWN    = 2'h1;
   localparam logic [1:0] DIR_NEIGH  = 2'h2;
   localparam logic [1:0] DIR_TRIG   = 2'h3;
   localparam logic [1:0] PROTECTION_LEVEL_LOCK  = 2'h3;
   localparam int QUICK_DELAY_CYC    = 3;   // trigger pin to reference, quick path
   localparam int SLOW_DELAY_CYC     = 5;   // trigger pin to reference via counter restart

   // capture configuration of one channel
   typedef struct packed {
      logic [3:0] flt;
      logic [1:0] psc;
      logic [1:0] dir;
   } tmc_cap_cfg_t;

   // latched ahb address phase
   typedef struct packed {
      logic       valid;
      logic       wr;
      logic [7:0] addr;
   } tmc_ahb_req_t;

   // consecutive samples needed per filter code
   function automatic logic [3:0] tmc_flt_len(input logic [3:0] code);
      case (code)
         4'h0:                   tmc_flt_len = 4'h1;
         4'h1:                   tmc_flt_len = 4'h2;
         4'h2:                   tmc_flt_len = 4'h4;
         4'h4, 4'h6, 4'h8, 4'hB, 4'hE: tmc_flt_len = 4'h6;
         4'hA, 4'hD:             tmc_flt_len = 4'h5;
         default:                tmc_flt_len = 4'h8;
      endcase
   endfunction

   // mask of sampling-clock pulses skipped: 0 for /1 up to 1F for /32
   function automatic logic [4:0] tmc_flt_mask(input logic [3:0] code);
      case (code)
         4'h4, 4'h5:       tmc_flt_mask = 5'h01;
         4'h6, 4'h7:       tmc_flt_mask = 5'h03;
         4'h8, 4'h9:       tmc_flt_mask = 5'h07;
         4'hA, 4'hB, 4'hC: tmc_flt_mask = 5'h0F;
         4'hD, 4'hE, 4'hF: tmc_flt_mask = 5'h1F;
         default:          tmc_flt_mask = 5'h00;
      endcase
   endfunction

   // capture configuration fields of channel ch
   function automatic tmc_cap_cfg_t tmc_cap_cfg(input logic [15:0] mode, input int ch);
      tmc_cap_cfg = (ch == 0) ? mode[7:0] : mode[15:8];
   endfunction

endpackage

// ### rtl/tmc_flt.sv
/*
 * input capture digital filter for one channel pin: two-flop synchroniser,
 * sampling-rate selection and consecutive-sample event counter.
 * assumes dts_en_i is a one-cycle enable at the dead-time sampling rate.
 */
module tmc_flt (
   input  wire logic       clk_i,
   input  wire logic       reset_n_i,
   input  wire logic       pin_i,
   input  wire logic       dts_en_i,
   input  wire logic [3:0] flt_code_i,
   output logic            filtered_o
);
   import tmc_pkg::*;

   logic       sync1_r;
   logic       sync2_r;
   logic [4:0] div_cnt_r;
   logic [3:0] run_cnt_r;
   logic [3:0] len;
   logic       samp_en;

   // -------------------------------------------------------------
   // synchroniser and sample enable
   // -------------------------------------------------------------
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         sync1_r <= 1'b0;
         sync2_r <= 1'b0;
      end else begin
         sync1_r <= pin_i;
         sync2_r <= sync1_r;
      end
   end

   // counts sampling-clock pulses for the divided rates
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         div_cnt_r <= 5'h00;
      end else if (dts_en_i) begin
         div_cnt_r <= div_cnt_r + 5'h01;
      end
   end

   // codes 1..3 sample every kernel cycle, code 0 on every dts enable, others on divided dts enable
   always_comb begin
      len = tmc_flt_len(flt_code_i);
      if (flt_code_i == 4'h1 || flt_code_i == 4'h2 || flt_code_i == 4'h3) begin
         samp_en = 1'b1;
      end else begin
         samp_en = dts_en_i && ((div_cnt_r & tmc_flt_mask(flt_code_i)) == 5'h00);
      end
   end

   // -------------------------------------------------------------
   // event counter
   // -------------------------------------------------------------
   // output flips only after len agreeing samples of the new level
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         run_cnt_r  <= 4'h0;
         filtered_o <= 1'b0;
      end else if (samp_en) begin
         if (sync2_r == filtered_o) begin
            run_cnt_r <= 4'h0;
         end else if (run_cnt_r + 4'h1 >= len) begin
            filtered_o <= sync2_r;
            run_cnt_r  <= 4'h0;
         end else begin
            run_cnt_r <= run_cnt_r + 4'h1;
         end
      end
   end

   a_filter_run_len: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      $changed(filtered_o) |-> $past(samp_en) && ($past(run_cnt_r) + 4'h1 == $past(len)))
      else $error("filter output changed before enough samples");

   a_filter_dts_only: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (flt_code_i == 4'h0 && !dts_en_i) |=> $stable(filtered_o))
      else $error("unfiltered input moved without sampling pulse");

   a_filter_slow_rate: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (flt_code_i[3:2] != 2'h0 && div_cnt_r[0]) |=> $stable(filtered_o))
      else $error("divided filter sampled on skipped pulse");

endmodule

// ### rtl/tmc_mode_ctrl.sv
/*
 * timer channel 0/1 mode control: pwm reference generation for channel 0,
 * compare value preload, quick trigger response, channel direction and
 * input source selection, capture filter and edge prescaler, ahb-lite registers.
 * assumes counter, count direction and update events come from timer logic on
 * clk_i; trigger and capture pins are asynchronous and are synchronised here.
 */
// Decided for this implementation: register access over AHB-Lite and the placing of the registers.
module tmc_mode_ctrl (
   input  wire logic        clk_i,
   input  wire logic        reset_n_i,
   input  wire logic        hsel_i,
   input  wire logic [31:0] haddr_i,
   input  wire logic [1:0]  htrans_i,
   input  wire logic        hwrite_i,
   input  wire logic [2:0]  hsize_i,
   input  wire logic [31:0] hwdata_i,
   input  wire logic        hready_i,
   output logic [31:0]      hrdata_o,
   output logic             hreadyout_o,
   output logic             hresp_o,
   input  wire logic [15:0] counter_i,
   input  wire logic        count_down_i,
   input  wire logic        update_evt_i,
   input  wire logic        trigger_i,
   input  wire logic [1:0]  cap_pin_i,
   output logic             chan0_output_pin_o,
   output logic             trig_restart_o,
   output logic [1:0]       capture_evt_o
);
   import tmc_pkg::*;

   tmc_ahb_req_t req_r;
   logic [15:0]  mode_r;
   logic [15:0]  mode_nxt;
   logic [7:0]   ctrl_r;
   logic [15:0]  cv_buf_r;
   logic [15:0]  cv_active_r;
   logic [31:0]  rd_mux;
   logic         wr_go;
   logic         wr_mode;
   logic         locked;
   logic [1:0]   chan_on;
   logic [1:0]   dts_cnt_r;
   logic         dts_en;
   logic         trg_s1_r;
   logic         trg_s2_r;
   logic         trg_s3_r;
   logic         trig_rise;
   logic [2:0]   cmp_code;
   logic [2:0]   code_prev_r;
   logic         is_pwm;
   logic         cmp_now;
   logic         cmp_prev_r;
   logic         cmp_chg;
   logic         pwm_entry;
   logic         quick_pwm;
   logic         quick_hit;
   logic [1:0]   filt;

   // -------------------------------------------------------------
   // ahb-lite slave
   // -------------------------------------------------------------
   // address phase latch; read data phase gets one wait state
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         req_r <= '0;
      end else if (hready_i) begin
         req_r.valid <= hsel_i && htrans_i[1];
         req_r.wr    <= hwrite_i;
         req_r.addr  <= (haddr_i[31:8] == 24'h000000) ? haddr_i[7:0] : 8'hFF;
      end
   end

   assign wr_go   = req_r.valid && req_r.wr;
   assign wr_mode = wr_go && req_r.addr == ADDR_MODE;
   assign chan_on = ctrl_r[CTRL_ON_LSB +: 2];

   // read mux, unmapped addresses read as zero
   always_comb begin
      case (req_r.addr)
         ADDR_MODE: rd_mux = {16'h0000, mode_r};
         ADDR_CTRL: rd_mux = {24'h000000, ctrl_r};
         ADDR_CMPV: rd_mux = {16'h0000, cv_active_r};
         ADDR_STAT: rd_mux = {28'h0000000, trg_s2_r, filt, chan0_output_pin_o};
         default:   rd_mux = 32'h00000000;
      endcase
   end

   // ready drops for one cycle on reads, data sampled after writes settle
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         hreadyout_o <= 1'b1;
         hrdata_o    <= 32'h00000000;
         hresp_o     <= 1'b0;
      end else if (hready_i && hsel_i && htrans_i[1] && !hwrite_i) begin
         hreadyout_o <= 1'b0;
      end else if (!hreadyout_o) begin
         hreadyout_o <= 1'b1;
         hrdata_o    <= rd_mux;
      end
   end

   // -------------------------------------------------------------
   // registers
   // -------------------------------------------------------------
   assign locked = ctrl_r[CTRL_PROTECTION_LEVEL_LSB +: 2] == PROTECTION_LEVEL_LOCK && mode_r[1:0] == DIR_OUT;

   // write filtering for protection and active channels
   always_comb begin
      mode_nxt = hwdata_i[15:0];
      if (locked) begin
         mode_nxt[6:3] = mode_r[6:3];
      end
      if (chan_on[0]) begin
         mode_nxt[1:0] = mode_r[1:0];
      end
      if (chan_on[1]) begin
         mode_nxt[9:8] = mode_r[9:8];
      end
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         mode_r <= MODE_RESET;
      end else if (wr_mode) begin
         mode_r <= mode_nxt;
      end
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         ctrl_r <= CTRL_RESET;
      end else if (wr_go && req_r.addr == ADDR_CTRL) begin
         ctrl_r <= hwdata_i[7:0];
      end
   end

   // compare value: buffered until update event when preload is set
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         cv_buf_r    <= CMPV_RESET;
         cv_active_r <= CMPV_RESET;
      end else begin
         if (update_evt_i && mode_r[MODE_PRELOAD_BIT]) begin
            cv_active_r <= cv_buf_r;
         end
         if (wr_go && req_r.addr == ADDR_CMPV) begin
            cv_buf_r <= hwdata_i[15:0];
            if (!mode_r[MODE_PRELOAD_BIT]) begin
               cv_active_r <= hwdata_i[15:0];
            end
         end
      end
   end

   // -------------------------------------------------------------
   // dead-time sampling clock enable
   // -------------------------------------------------------------
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         dts_cnt_r <= 2'h0;
      end else begin
         dts_cnt_r <= dts_en ? 2'h0 : dts_cnt_r + 2'h1;
      end
   end

   always_comb begin
      case (ctrl_r[CTRL_DTS_LSB +: 2])
         2'h1:    dts_en = dts_cnt_r == 2'h1;
         2'h2:    dts_en = dts_cnt_r == 2'h3;
         default: dts_en = 1'b1;
      endcase
   end

   // -------------------------------------------------------------
   // trigger input
   // -------------------------------------------------------------
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         trg_s1_r <= 1'b0;
         trg_s2_r <= 1'b0;
         trg_s3_r <= 1'b0;
      end else begin
         trg_s1_r <= trigger_i;
         trg_s2_r <= trg_s1_r;
         trg_s3_r <= trg_s2_r;
      end
   end

   assign trig_rise = trg_s2_r && !trg_s3_r;

   // counter restart request, reference follows the counter two edges later
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         trig_restart_o <= 1'b0;
      end else begin
         trig_restart_o <= trig_rise;
      end
   end

   // -------------------------------------------------------------
   // channel 0 compare reference
   // -------------------------------------------------------------
   assign cmp_code  = mode_r[MODE_CMP_LSB +: 3];
   assign is_pwm    = mode_r[1:0] == DIR_OUT &&
                      (cmp_code == CMP_PWM0 || cmp_code == CMP_PWM1);
   assign quick_pwm = is_pwm && mode_r[MODE_QUICK_BIT];
   assign quick_hit = quick_pwm && trig_rise;
   assign pwm_entry = is_pwm && code_prev_r == CMP_TIMING;
   assign cmp_chg   = cmp_now != cmp_prev_r;

   // active level of the selected pwm mode
   always_comb begin
      if (cmp_code == CMP_PWM1) begin
         cmp_now = count_down_i ? (counter_i > cv_active_r)
                                : (counter_i >= cv_active_r);
      end else begin
         cmp_now = count_down_i ? (counter_i <= cv_active_r)
                                : (counter_i < cv_active_r);
      end
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         cmp_prev_r  <= 1'b0;
         code_prev_r <= CMP_TIMING;
      end else begin
         cmp_prev_r  <= cmp_now;
         code_prev_r <= cmp_code;
      end
   end

   // quick trigger wins, then entry from timing or a comparison change
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         chan0_output_pin_o <= 1'b0;
      end else if (quick_hit) begin
         chan0_output_pin_o <= 1'b1;
      end else if (is_pwm && (pwm_entry || cmp_chg)) begin
         chan0_output_pin_o <= cmp_now;
      end
   end

   // -------------------------------------------------------------
   // capture channels: filter, source select, prescaler
   // -------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_cap
         tmc_cap_cfg_t cfg;
         logic         src;
         logic         src_q_r;
         logic [2:0]   psc_cnt_r;
         logic [2:0]   psc_lim;

         assign cfg     = tmc_cap_cfg(mode_r, g);
         assign psc_lim = 3'((4'h1 << cfg.psc) - 4'h1);

         tmc_flt u_flt (
            .clk_i      (clk_i),
            .reset_n_i  (reset_n_i),
            .pin_i      (cap_pin_i[g]),
            .dts_en_i   (dts_en),
            .flt_code_i (cfg.flt),
            .filtered_o (filt[g])
         );

         // capture source per direction code
         always_comb begin
            case (cfg.dir)
               DIR_OWN:   src = filt[g];
               DIR_NEIGH: src = filt[1-g];
               DIR_TRIG:  src = trg_s2_r && ctrl_r[CTRL_TRGVLD_BIT];
               default:   src = 1'b0;
            endcase
         end

         // edge prescaler, cleared while the channel is off
         always_ff @(posedge clk_i or negedge reset_n_i) begin
            if (!reset_n_i) begin
               src_q_r          <= 1'b0;
               psc_cnt_r        <= 3'h0;
               capture_evt_o[g] <= 1'b0;
            end else begin
               src_q_r          <= src;
               capture_evt_o[g] <= 1'b0;
               if (!chan_on[g]) begin
                  psc_cnt_r <= 3'h0;
               end else if (cfg.dir != DIR_OUT && src && !src_q_r) begin
                  if (psc_cnt_r == psc_lim) begin
                     psc_cnt_r        <= 3'h0;
                     capture_evt_o[g] <= 1'b1;
                  end else begin
                     psc_cnt_r <= psc_cnt_r + 3'h1;
                  end
               end
            end
         end

         a_psc_off_clear: assert property (@(posedge clk_i) disable iff (!reset_n_i)
            !chan_on[g] |=> psc_cnt_r == 3'h0 && !capture_evt_o[g])
            else $error("prescaler counted while channel off");

         a_capture_period: assert property (@(posedge clk_i) disable iff (!reset_n_i)
            capture_evt_o[g] |-> $past(psc_cnt_r) == $past(psc_lim))
            else $error("capture before prescaler count reached");
      end
   endgenerate

   // -------------------------------------------------------------
   // checks
   // -------------------------------------------------------------
   a_pwm1_level: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (cmp_code == CMP_PWM1 && is_pwm && cmp_chg && !quick_hit)
      |=> chan0_output_pin_o == ($past(count_down_i) ? $past(counter_i) > $past(cv_active_r)
                                : $past(counter_i) >= $past(cv_active_r)))
      else $error("pwm1 reference level wrong");

   a_ref_hold: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (is_pwm && !pwm_entry && !cmp_chg && !quick_hit) |=> $stable(chan0_output_pin_o))
      else $error("pwm reference moved without cause");

   a_protection_level_lock: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (wr_mode && locked) |=> $stable(mode_r[6:3]))
      else $error("locked compare bits changed");

   a_preload_hold: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (mode_r[MODE_PRELOAD_BIT] && !update_evt_i) |=> $stable(cv_active_r))
      else $error("preloaded compare value changed early");

   a_quick_force: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      ($rose(trigger_i) && quick_pwm) ##2 quick_pwm |=> chan0_output_pin_o)
      else $error("quick trigger did not force reference");

   a_slow_restart: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      ($rose(trigger_i) && !trg_s1_r) |-> ##3 trig_restart_o)
      else $error("counter restart not issued on trigger");

   a_dir_locked: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (wr_mode && chan_on[0]) |=> $stable(mode_r[1:0]))
      else $error("direction changed while channel on");

endmodule

// ### test/tmc_pin_model.sv
/* square-wave source standing in for both channel capture pins.
   assumes run_i is held for multiples of 8 cycles; pin stays driven. */
module tmc_pin_model (
   input  wire logic clk_i,
   input  wire logic run_i,
   output logic      pin_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0] cnt_r = 3'h0;
   initial pin_o = 1'b0;
   // one rising edge every 16 cycles while running
   always @(posedge clk_i) begin
      if (run_i) begin
         cnt_r <= cnt_r + 3'h1;
         if (cnt_r == 3'h7) pin_o <= ~pin_o;
      end
   end
endmodule

// ### test/tb_top.sv
/* self-checking bench of tmc_mode_ctrl: registers, pwm, preload, trigger, capture.
   assumes one ahb-lite slave and the pin model on both channel inputs. */
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import tmc_pkg::*;
   logic        clk_i = 1'b0, reset_n_i = 1'b0, hwrite = 1'b0, down = 1'b0, upd = 1'b0;
   logic        trig = 1'b0, run = 1'b0, pin, rdy, outp, rst, rsp;
   logic [1:0]  htrans = 2'h0;
   logic [1:0]  capo;
   logic [15:0] cnt = 16'h0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rnd = 32'hCA61, rdv;
   int          fail_count = 0, num_checks = 0, caps = 0, n;
   // -------------------------------------------------------------
   // clock, design, pin model
   // -------------------------------------------------------------
   always #4 clk_i = ~clk_i;
   tmc_mode_ctrl uut (.clk_i(clk_i), .reset_n_i(reset_n_i), .hsel_i(1'b1), .haddr_i(haddr),
      .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(rdy),
      .hrdata_o(hrdata), .hreadyout_o(rdy), .hresp_o(rsp), .counter_i(cnt), .count_down_i(down),
      .update_evt_i(upd), .trigger_i(trig), .cap_pin_i({pin, pin}),
      .chan0_output_pin_o(outp), .trig_restart_o(rst), .capture_evt_o(capo));
   tmc_pin_model pins (.clk_i(clk_i), .run_i(run), .pin_o(pin));
   always @(posedge clk_i) if (capo[0] === 1'b1) caps <= caps + 1;
   // -------------------------------------------------------------
   // helpers
   // -------------------------------------------------------------
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [31:0] exp_caps(input int edges, input int p);
      return 32'(edges >> p);
   endfunction
   // pwm mode 1 level: up active from compare on, down active above compare
   function automatic logic pwm1_exp(input logic [15:0] c, input logic [15:0] v, input logic d);
      return d ? (c > v) : (c >= v);
   endfunction
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge clk_i); while (rdy !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk_i); while (rdy !== 1'b1);
      rdv = hrdata;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      num_checks++;
      if (g !== e) begin
         fail_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(rdv, e);
      chk({31'h0, rsp}, 32'h0);
   endtask
   // pin toggles for c cycles, then lets the capture path settle
   task automatic pulse(input int c);
      run <= 1'b1;
      repeat (c) @(posedge clk_i);
      run <= 1'b0;
      repeat (20) @(posedge clk_i);
   endtask
   task automatic end_sim;
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // -------------------------------------------------------------
   // main sequence
   // -------------------------------------------------------------
   initial begin
      repeat (2) @(posedge clk_i);
      reset_n_i <= 1'b1;
      @(posedge clk_i);
      rchk(ADDR_MODE, 32'(MODE_RESET));
      rchk(8'h40, 32'h0);
      rnd = lfsr(rnd);
      wr(ADDR_MODE, rnd);
      rchk(ADDR_MODE, {16'h0, rnd[15:0]});
      wr(ADDR_CTRL, 32'h3);
      wr(ADDR_MODE, ~rnd);
      rchk(ADDR_MODE, {16'h0, ~rnd[15:10], rnd[9:8], ~rnd[7:2], rnd[1:0]});
      wr(ADDR_CTRL, 32'h0);
      wr(ADDR_MODE, 32'h0);
      wr(ADDR_CTRL, 32'hC);
      wr(ADDR_MODE, 32'h7B);
      rchk(ADDR_MODE, 32'h3);
      wr(ADDR_CTRL, 32'h10);
      wr(ADDR_MODE, 32'h70);
      wr(ADDR_CMPV, 32'h64);
      // below, equal counting up; equal, above counting down
      for (n = 0; n < 4; n++) begin
         @(posedge clk_i);
         down <= (n > 1);
         cnt <= 16'h63 + 16'(n - n / 2);
         repeat (4) @(posedge clk_i);
         #1 chk({31'h0, outp}, 32'(n % 2));
      end
      @(posedge clk_i);
      wr(ADDR_MODE, 32'h78);
      wr(ADDR_CMPV, 32'hC8);
      rchk(ADDR_CMPV, 32'h64);
      upd <= 1'b1;
      @(posedge clk_i);
      upd <= 1'b0;
      rchk(ADDR_CMPV, 32'hC8);
      // random counter and compare pairs, compare value taken on an update event
      for (n = 0; n < 4; n++) begin
         rnd = lfsr(rnd);
         wr(ADDR_CMPV, {16'h0, rnd[15:0]});
         upd <= 1'b1;
         cnt <= {rnd[7:0], rnd[15:8]};
         down <= rnd[16];
         @(posedge clk_i);
         upd <= 1'b0;
         repeat (3) @(posedge clk_i);
         #1 chk({31'h0, outp}, {31'h0, pwm1_exp(cnt, rnd[15:0], down)});
         @(posedge clk_i);
      end
      wr(ADDR_MODE, 32'h7C);
      cnt <= 16'h0;
      down <= 1'b0;
      repeat (4) @(posedge clk_i);
      trig <= 1'b1;
      for (n = 1; n < 9; n++) begin
         @(posedge clk_i);
         #1 if (outp === 1'b1) break;
      end
      chk(32'(n), 32'h3);
      chk({31'h0, rst}, 32'h1);
      @(posedge clk_i);
      trig <= 1'b0;
      // leftover edges must be dropped when the channel is switched off
      for (int p = 0; p < 4; p++) begin
         // odd passes take the neighbouring pin, which carries the same wave
         wr(ADDR_MODE, 32'h1010 | (32'(p) << 2) | (p[0] ? 32'h2 : 32'h1));
         wr(ADDR_CTRL, 32'h1);
         pulse(64);
         wr(ADDR_CTRL, 32'h0);
         wr(ADDR_CTRL, 32'h1);
         n = caps;
         pulse(192);
         chk(32'(caps - n), exp_caps(12, p));
         wr(ADDR_CTRL, 32'h0);
      end
      // internal trigger as capture source, one capture per rising edge
      wr(ADDR_MODE, 32'h3);
      wr(ADDR_CTRL, 32'h21);
      n = caps;
      repeat (3) begin
         trig <= 1'b1;
         repeat (4) @(posedge clk_i);
         trig <= 1'b0;
         repeat (4) @(posedge clk_i);
      end
      repeat (8) @(posedge clk_i);
      chk(32'(caps - n), 32'h3);
      end_sim;
   end
   // hang guard, far beyond the roughly 1400 cycles the run needs
   initial begin
      repeat (6000) @(posedge clk_i);
      fail_count++;
      end_sim;
   end
endmodule
